// ===== rtl/pas_consts.vh
// Constants for the port analog input select block
`ifndef PAS_CONSTS_VH
`define PAS_CONSTS_VH
`define PAS_ADDR_PRIMARY 12'h000
`define PAS_ADDR_SECONDARY 12'h004
`define PAS_ADDR_PORTA_IN 12'h008
`define PAS_ADDR_PORTB_IN 12'h00c
`define PAS_ADDR_PORTE_IN 12'h010
`define PAS_PRIMARY_RESET 8'hff
`define PAS_SEC_MASK 8'h1f
`define PAS_SEC_ONES 5'h1f
`define PAS_SMALL_MASK 8'h1f
`define PAS_FULL_MASK 8'hff
`define PAS_ZERO8 8'h00
`define PAS_ZERO32 32'h00000000
`define PAS_PAD24 24'h000000
`endif

// ===== rtl/pas_pin_gate.v
// One pin's digital input gate
`timescale 1ns/1ps
module pas_pin_gate (
    input wire pad_i,
    input wire sel_i,
    output wire din_o
);
    assign din_o = pad_i & ~sel_i;
endmodule

// ===== rtl/pas_top.v
// Port analog input select block with APB register slave
//
// What this block does
// - Each analog pin has own select bit
// - Selected pin: input buffer off, reads zero
// - Select bits never touch output path
// - Output pins still drive latch when selected
// - Small package: primary bits 7..5 read 0 and writes clear them; reset sets them, gating Port E input reads
// - Secondary bits 4..0 map RB0,RB4,RB1,RB3,RB2
// - Secondary reset default follows fuse bit
`timescale 1ns/1ps
`include "pas_consts.vh"
module pas_top #(
    parameter SMALL_PKG = 0
) (
    input wire CLK_I,
    input wire RST_B_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    input wire [3:0] PSTRB_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire PORTB_ANALOG_DEFAULT_FUSE_I,
    input wire [7:0] PORTA_PAD_I,
    input wire [7:0] PORTB_PAD_I,
    input wire [2:0] PORTE_PAD_I,
    input wire [7:0] PORTA_LAT_I,
    input wire [7:0] PORTB_LAT_I,
    input wire [2:0] PORTE_LAT_I,
    input wire [7:0] PORTA_DIR_I,
    input wire [7:0] PORTB_DIR_I,
    input wire [2:0] PORTE_DIR_I,
    output reg [7:0] PORTA_DIN_O,
    output reg [7:0] PORTB_DIN_O,
    output reg [2:0] PORTE_DIN_O,
    output reg [7:0] PORTA_OUT_O,
    output reg [7:0] PORTB_OUT_O,
    output reg [2:0] PORTE_OUT_O,
    output reg [7:0] PORTA_OE_O,
    output reg [7:0] PORTB_OE_O,
    output reg [2:0] PORTE_OE_O
);
    reg [7:0] analog_select_primary;
    reg [7:0] analog_select_secondary;
    reg [7:0] next_rdata;
    reg next_err;
    wire [7:0] impl_mask;
    wire [7:0] sel_a;
    wire [7:0] sel_b;
    wire [2:0] sel_e;
    wire [7:0] din_a;
    wire [7:0] din_b;
    wire [2:0] din_e;
    wire [18:0] pad_all;
    wire [18:0] sel_all;
    wire [18:0] din_all;
    wire setup;
    wire wr_go;

    assign impl_mask = (SMALL_PKG != 0) ? `PAS_SMALL_MASK : `PAS_FULL_MASK;
    assign setup = PSEL_I & ~PENABLE_I;
    assign wr_go = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & PSTRB_I[0];

    // Pin to select bit mapping; RA2/RA3/RA4 have no legible bit
    assign sel_a = {2'b00, analog_select_primary[4], 2'b00, 1'b0,
                    analog_select_primary[1], analog_select_primary[0]};
    assign sel_b = {3'b000, analog_select_secondary[3], analog_select_secondary[1],
                    analog_select_secondary[0], analog_select_secondary[2],
                    analog_select_secondary[4]};
    assign sel_e = analog_select_primary[7:5];
    assign pad_all = {PORTE_PAD_I, PORTB_PAD_I, PORTA_PAD_I};
    assign sel_all = {sel_e, sel_b, sel_a};
    assign din_a = din_all[7:0];
    assign din_b = din_all[15:8];
    assign din_e = din_all[18:16];

    genvar g;
    generate
        for (g = 0; g < 19; g = g + 1) begin : pin
            pas_pin_gate u_gate (
                .pad_i(pad_all[g]),
                .sel_i(sel_all[g]),
                .din_o(din_all[g])
            );
        end
    endgenerate

    always @* begin
        next_rdata = `PAS_ZERO8;
        next_err = 1'b0;
        case (PADDR_I)
            `PAS_ADDR_PRIMARY: next_rdata = analog_select_primary & impl_mask;
            `PAS_ADDR_SECONDARY: next_rdata = analog_select_secondary & `PAS_SEC_MASK;
            `PAS_ADDR_PORTA_IN: next_rdata = din_a;
            `PAS_ADDR_PORTB_IN: next_rdata = din_b;
            `PAS_ADDR_PORTE_IN: next_rdata = {5'b00000, din_e};
            default: next_err = 1'b1;
        endcase
    end

    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            analog_select_primary <= `PAS_PRIMARY_RESET;
            analog_select_secondary <= PORTB_ANALOG_DEFAULT_FUSE_I ? `PAS_SEC_MASK : `PAS_ZERO8;
            PRDATA_O <= `PAS_ZERO32;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O <= setup;
            if (setup) begin
                PRDATA_O <= PWRITE_I ? `PAS_ZERO32 : {`PAS_PAD24, next_rdata};
                PSLVERR_O <= next_err;
            end else if (PREADY_O) begin
                PRDATA_O <= `PAS_ZERO32;
                PSLVERR_O <= 1'b0;
            end
            if (wr_go && PADDR_I == `PAS_ADDR_PRIMARY) begin
                analog_select_primary <= PWDATA_I[7:0] & impl_mask;
            end
            if (wr_go && PADDR_I == `PAS_ADDR_SECONDARY) begin
                analog_select_secondary <= PWDATA_I[7:0] & `PAS_SEC_MASK;
            end
        end
    end

    // Pin outputs; OUT/OE independent of select bits, DIN gated by them
    always @(posedge CLK_I) begin
        if (!RST_B_I) begin
            PORTA_DIN_O <= `PAS_ZERO8;
            PORTB_DIN_O <= `PAS_ZERO8;
            PORTE_DIN_O <= 3'b000;
            PORTA_OUT_O <= `PAS_ZERO8;
            PORTB_OUT_O <= `PAS_ZERO8;
            PORTE_OUT_O <= 3'b000;
            PORTA_OE_O <= `PAS_ZERO8;
            PORTB_OE_O <= `PAS_ZERO8;
            PORTE_OE_O <= 3'b000;
        end else begin
            PORTA_DIN_O <= din_a;
            PORTB_DIN_O <= din_b;
            PORTE_DIN_O <= din_e & impl_mask[7:5];
            PORTA_OUT_O <= PORTA_LAT_I;
            PORTB_OUT_O <= PORTB_LAT_I;
            PORTE_OUT_O <= PORTE_LAT_I;
            PORTA_OE_O <= ~PORTA_DIR_I;
            PORTB_OE_O <= ~PORTB_DIR_I;
            PORTE_OE_O <= ~PORTE_DIR_I;
        end
    end
endmodule

// ===== sim/pas_top_assertions.sv
// Port-level checker for the analog select block
`timescale 1ns/1ps
module pas_chk(
input logic CLK_I,
input logic RST_B_I,
input logic PSEL_I,
input logic PENABLE_I,
input logic PREADY_O,
input logic [31:0] PRDATA_O,
input logic [7:0] PORTA_PAD_I,
input logic [7:0] PORTA_LAT_I,
input logic [7:0] PORTA_DIR_I,
input logic [7:0] PORTA_DIN_O,
input logic [7:0] PORTA_OUT_O,
input logic [7:0] PORTA_OE_O
);
default clocking @(posedge CLK_I); endclocking
default disable iff (!RST_B_I);
out_lat_a: assert property ($past(RST_B_I) |-> PORTA_OUT_O == $past(PORTA_LAT_I)) else $error("out");
oe_dir_a: assert property ($past(RST_B_I) |-> PORTA_OE_O == ~$past(PORTA_DIR_I)) else $error("oe");
din_pad_a: assert property ((PORTA_DIN_O & ~$past(PORTA_PAD_I)) == 8'h00) else $error("din");
rdy_setup_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O) else $error("rdy");
rdy_one_a: assert property (PREADY_O |=> !PREADY_O) else $error("pulse");
rdy_acc_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I) else $error("acc");
rd_hi_a: assert property (PREADY_O |-> PRDATA_O[31:8] == 24'h000000) else $error("hi");
rd_clr_a: assert property (!PREADY_O |-> PRDATA_O == 32'h00000000) else $error("clr");
endmodule
bind pas_top pas_chk u_chk(.*);

// ===== sim/tb_top.sv
// Self-checking bench for the analog select block
`timescale 1ns/1ps
module tb_top;
logic CLK_I = 0, RST_B_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, PORTB_ANALOG_DEFAULT_FUSE_I = 0;
logic [11:0] PADDR_I = 0;
logic [31:0] PWDATA_I = 0, PRDATA_O, rd;
logic [3:0] PSTRB_I = 4'hf;
logic PREADY_O, PSLVERR_O, er;
logic [7:0] PORTA_PAD_I = 8'hff, PORTB_PAD_I = 8'hff, PORTA_LAT_I = 0, PORTB_LAT_I = 0, PORTA_DIR_I = 8'hff;
logic [7:0] PORTB_DIR_I = 8'hff, PORTA_DIN_O, PORTB_DIN_O, PORTA_OUT_O, PORTB_OUT_O, PORTA_OE_O, PORTB_OE_O;
logic [2:0] PORTE_PAD_I = 3'h7, PORTE_LAT_I = 0, PORTE_DIR_I = 3'h7, PORTE_DIN_O, PORTE_OUT_O, PORTE_OE_O;
int failures = 0, n_checks = 0;
int pin [5] = '{2, 3, 1, 4, 0};
pas_top dut(.*);
initial forever #12.5 CLK_I = ~CLK_I;
task summarize;
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
        failures++;
        $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge CLK_I);
    PSEL_I <= 1; PENABLE_I <= 0; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    k = 0;
    do begin
        @(posedge CLK_I);
        k++;
    end while (PREADY_O !== 1'b1 && k < 20);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 0; PENABLE_I <= 0;
    if (k >= 20) begin
        failures++;
        summarize;
    end
endtask
task t_reset;
    apb(0, 12'h000, 0); chk(rd, 32'h000000ff);
    apb(0, 12'h004, 0); chk(rd, 32'h00000000);
    apb(1, 12'h004, 32'h000000ff); apb(0, 12'h004, 0); chk(rd, 32'h0000001f);
    apb(0, 12'h014, 0); chk(er, 1'b1);
endtask
task t_fuse;
    @(posedge CLK_I);
    PORTB_ANALOG_DEFAULT_FUSE_I <= 1;
    RST_B_I <= 0;
    repeat (8) @(posedge CLK_I);
    RST_B_I <= 1;
    apb(0, 12'h004, 0); chk(rd, 32'h0000001f);
    apb(0, 12'h00c, 0); chk(rd, 32'h000000e0);
    apb(0, 12'h000, 0); chk(rd, 32'h000000ff);
endtask
task t_gate;
    PORTA_DIR_I <= 8'h00; PORTA_LAT_I <= 8'ha5; PORTB_DIR_I <= 8'h0f; PORTB_LAT_I <= 8'h3c;
    PORTE_DIR_I <= 3'h2; PORTE_LAT_I <= 3'h5;
    apb(0, 12'h008, 0); chk(rd, 32'h000000dc);
    chk(PORTA_OUT_O, 8'ha5);
    chk(PORTA_OE_O, 8'hff);
    chk({PORTB_OUT_O, PORTE_OE_O}, {8'h3c, 3'h5});
    apb(0, 12'h010, 0); chk(rd, 32'h00000000);
    apb(1, 12'h000, 32'h00000000); apb(0, 12'h008, 0); chk(rd, 32'h000000ff);
    chk(PORTE_DIN_O, 3'h7);
endtask
task t_portb;
    for (int i = 0; i < 5; i++) begin
        apb(1, 12'h004, 32'h1 << i); apb(0, 12'h00c, 0);
        chk(rd, 32'hff & ~(32'h1 << pin[i]));
    end
endtask
initial begin
    repeat (8) @(posedge CLK_I);
    RST_B_I <= 1;
    t_reset;
    t_gate;
    t_portb;
    t_fuse;
    summarize;
end
endmodule
